// *** pbc_pkg.sv ***
// Package of constants for the boot clock configuration block.
`default_nettype none
package pbc_pkg;
    localparam int unsigned CFG_WIDTH = 6;
    localparam int unsigned BUS_WIDTH = 24;
    localparam int unsigned PLL_SEL_BIT = 5;
    localparam int unsigned MULT_MSB = 4;
    localparam int unsigned MULT_WIDTH = 5;
    localparam logic [5:0] CFG_RESET = 6'h00;
    localparam logic [4:0] MULT_MIN = 5'h05;
    localparam logic [4:0] MULT_MAX = 5'h1f;
    localparam logic [1:0] MODE_ONE = 2'h1;
    localparam logic [1:0] MODE_TWO = 2'h2;
    typedef enum logic [0:0] {
        PBC_OPEN = 1'b0,
        PBC_LOCKED = 1'b1
    } pbc_lock_type;
endpackage
`default_nettype wire

// *** pbc_boot_clock.sv ***
// Boot configuration location that picks PLL or direct video clocking.
//
// Behaviour
// - Bit 5 written one selects PLL multiplication of the input clock.
// - Multiplication factor is the unsigned value of bits 4 to 0.
// - The location accepts a write only after a reset cycle.
// - After one write, further writes are ignored until next reset.
// - Only the low six bus bits are captured; host uses normal writes.
// - PLL used only in mode 1; mode 2 or times-one clocks directly.
// - PLL mode multiplies a slow input clock by the programmed factor.
`default_nettype none
module pbc_boot_clock (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic cfg_wr_stb,
    input wire logic [23:0] muxed_addr_data_bus,
    input wire logic [1:0] video_mode,
    input wire logic times_one,
    output logic pll_enable,
    output logic [4:0] pll_mult,
    output logic cfg_locked,
    output logic factor_bad
);
    // Lock state and the six-bit location that it guards.
    pbc_pkg::pbc_lock_type lock_state;
    logic [5:0] pll_boot_config;
    // Values worked out each cycle and registered into the outputs below.
    logic next_pll_use;
    logic next_factor_bad;
    // High in a cycle in which a strobe meets the open lock; a reset in that cycle still wins.
    logic cfg_take;
    // Reset as seen one edge late; only the checks at the bottom read it.
    logic rst_trail;

    // The factor field of a location value, as an unsigned number.
    // Logic and checks both read it here, so they cannot drift apart.
    function automatic logic [4:0] cfg_factor(input logic [5:0] cfg);
        cfg_factor = cfg[pbc_pkg::MULT_MSB:0];
    endfunction

    // The part of the host bus that a boot write may carry.
    // The upper lines still hold address or junk and must never leak in.
    function automatic logic [5:0] cfg_from_bus(input logic [23:0] bus);
        cfg_from_bus = bus[pbc_pkg::CFG_WIDTH-1:0];
    endfunction

    // The PLL may run only with the select bit set, in mode 1, times-one off.
    // Any other combination falls back to the full-rate clock on the pin.
    function automatic logic pll_wanted(
        input logic [5:0] cfg,
        input logic [1:0] mode,
        input logic one_x
    );
        pll_wanted = cfg[pbc_pkg::PLL_SEL_BIT] && (mode == pbc_pkg::MODE_ONE) && !one_x;
    endfunction

    // A write is taken only while the lock is open. Reset wins over a strobe
    // in the same cycle, so a strobe inside reset never uses up the one write.
    always_comb begin
        cfg_take = cfg_wr_stb && (lock_state == pbc_pkg::PBC_OPEN);
    end

    // Write lock: opened by every reset, closed by the first strobe after it.
    // A strobe while already locked leaves it locked, which is harmless.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lock_state <= pbc_pkg::PBC_OPEN;
        end else if (cfg_wr_stb) begin
            lock_state <= pbc_pkg::PBC_LOCKED;
        end
    end

    // Location capture: only the low six bus bits, and only once per reset.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pll_boot_config <= pbc_pkg::CFG_RESET;
        end else if (cfg_take) begin
            pll_boot_config <= cfg_from_bus(muxed_addr_data_bus);
        end
    end

    // Clock source and the low-factor test, both from the stored location.
    always_comb begin
        next_pll_use = pll_wanted(pll_boot_config, video_mode, times_one);
        next_factor_bad = next_pll_use
            && (cfg_factor(pll_boot_config) < pbc_pkg::MULT_MIN);
    end

    // Clock select output; low means the pin clock drives video directly.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pll_enable <= 1'b0;
        end else begin
            pll_enable <= next_pll_use;
        end
    end

    // Factor output. It is held even while the PLL is bypassed, so that
    // software reads back what was written whatever the mode.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pll_mult <= cfg_factor(pbc_pkg::CFG_RESET);
        end else begin
            pll_mult <= cfg_factor(pll_boot_config);
        end
    end

    // Lock status output; it trails the internal lock by one edge.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cfg_locked <= 1'b0;
        end else begin
            cfg_locked <= (lock_state == pbc_pkg::PBC_LOCKED);
        end
    end

    // Flags an illegal low factor so software can see the host slip. The
    // factor is not clamped, since keeping it in range is the host's duty.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            factor_bad <= 1'b0;
        end else begin
            factor_bad <= next_factor_bad;
        end
    end

    // Reset delayed by one edge. On the edge that ends a reset the release is
    // already visible, yet every flop still took its reset branch there, so
    // the checks below are held off on that edge as well.
    always_ff @(posedge core_clk) begin
        rst_trail <= sys_rst;
    end

    // Steps of a boot write, shared by the checks below.
    sequence s_open_write;
        cfg_wr_stb && (lock_state == pbc_pkg::PBC_OPEN);
    endsequence
    sequence s_lock_closed;
        lock_state == pbc_pkg::PBC_LOCKED;
    endsequence
    sequence s_flag_raised;
        cfg_locked;
    endsequence

    // Once locked, the location keeps its value until the next reset.
    a_second_write_ignored: assert property (@(posedge core_clk)
        disable iff (sys_rst || rst_trail)
        s_lock_closed |=> $stable(pll_boot_config))
        else $error("Boot location changed after lock.");

    // The first write after reset lands on the next edge, low six bits only.
    a_first_write_taken: assert property (@(posedge core_clk)
        disable iff (sys_rst || rst_trail)
        s_open_write |=> pll_boot_config == cfg_from_bus($past(muxed_addr_data_bus)))
        else $error("First boot write not captured.");

    // A strobe closes the lock on the next edge and shows the flag one later.
    a_lock_after_write: assert property (@(posedge core_clk)
        disable iff (sys_rst || rst_trail)
        cfg_wr_stb |=> s_lock_closed ##1 s_flag_raised)
        else $error("Lock not set after write.");

    // Reset always reopens the location for one new write.
    a_reset_opens_lock: assert property (@(posedge core_clk)
        sys_rst |=> lock_state == pbc_pkg::PBC_OPEN)
        else $error("Reset did not reopen boot location.");

    // Reset clears every output on the edge that samples it.
    a_reset_clears_outputs: assert property (@(posedge core_clk)
        sys_rst |=> !pll_enable && !cfg_locked && !factor_bad
            && (pll_mult == cfg_factor(pbc_pkg::CFG_RESET)))
        else $error("Outputs not cleared by reset.");

    // A strobe inside reset is never captured.
    a_reset_blocks_write: assert property (@(posedge core_clk)
        sys_rst |=> pll_boot_config == pbc_pkg::CFG_RESET)
        else $error("Location written during reset.");

    // The factor output follows the location with one edge of delay.
    a_mult_follows_cfg: assert property (@(posedge core_clk)
        disable iff (sys_rst || rst_trail)
        ##1 pll_mult == cfg_factor($past(pll_boot_config)))
        else $error("Multiplier output does not follow location.");

    // Outside mode 1, or in times-one, the PLL stays off.
    a_pll_mode_gate: assert property (@(posedge core_clk)
        disable iff (sys_rst || rst_trail)
        (video_mode != pbc_pkg::MODE_ONE || times_one) |=> !pll_enable)
        else $error("PLL enabled outside mode 1.");

    // Mode 2 always runs from the full-rate pin clock.
    a_mode_two_direct: assert property (@(posedge core_clk)
        disable iff (sys_rst || rst_trail)
        video_mode == pbc_pkg::MODE_TWO |=> !pll_enable)
        else $error("PLL enabled in mode 2.");

    // The select bit turns the PLL on in mode 1 without times-one.
    a_pll_select_bit: assert property (@(posedge core_clk)
        disable iff (sys_rst || rst_trail)
        pll_boot_config[pbc_pkg::PLL_SEL_BIT] && video_mode == pbc_pkg::MODE_ONE
            && !times_one |=> pll_enable)
        else $error("PLL select bit not honoured.");

    // A clear select bit keeps the PLL off in every mode.
    a_pll_off_unselected: assert property (@(posedge core_clk)
        disable iff (sys_rst || rst_trail)
        !pll_boot_config[pbc_pkg::PLL_SEL_BIT] |=> !pll_enable)
        else $error("PLL enabled without select bit.");

    // The low-factor flag agrees with the clock select and factor outputs.
    a_low_factor_flag: assert property (@(posedge core_clk)
        disable iff (sys_rst || rst_trail)
        factor_bad == (pll_enable && (pll_mult < pbc_pkg::MULT_MIN)))
        else $error("Low factor flag wrong.");

    // Without a strobe the open location keeps its value.
    a_no_write_open: assert property (@(posedge core_clk)
        disable iff (sys_rst || rst_trail)
        !cfg_wr_stb && lock_state == pbc_pkg::PBC_OPEN |=> $stable(pll_boot_config))
        else $error("Location changed without a write.");
endmodule
`default_nettype wire

// *** pbc_host_model.sv ***
// Host model issuing boot configuration writes.
`default_nettype none
module pbc_host_model (
    input wire logic core_clk,
    input wire logic go,
    input wire logic [5:0] val,
    output logic stb = 1'h0,
    output logic [23:0] bus = 24'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus toggles so stale data is never mistaken for a write.
    always_ff @(posedge core_clk) begin
        stb <= go;
        bus <= go ? {18'h2aaaa, val} : ~bus;
    end
endmodule
`default_nettype wire

// *** pbc_boot_clock_tb.sv ***
// Self-checking bench for the boot clock block.
`default_nettype none
module pbc_boot_clock_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'h0, sys_rst = 1'h1, go = 1'h0, t1 = 1'h0, stb, en, lk, bad;
    logic [5:0] val = 6'h00;
    logic [1:0] md = 2'h1;
    logic [4:0] mult;
    logic [23:0] bus;
    int num_errors = 0, comparisons = 0;
    // Rows: data, mode, times-one, expected enable.
    logic [9:0] rows [4] = '{10'h2a5, 10'h3f6, 10'h258, 10'h054};
    pbc_host_model host (.core_clk(core_clk), .go(go), .val(val), .stb(stb), .bus(bus));
    pbc_boot_clock DUT (.core_clk(core_clk), .sys_rst(sys_rst), .cfg_wr_stb(stb),
        .muxed_addr_data_bus(bus), .video_mode(md), .times_one(t1),
        .pll_enable(en), .pll_mult(mult), .cfg_locked(lk), .factor_bad(bad));
    // Clock of 50 ns period.
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    task automatic check(input string n, input logic [4:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Lock is awaited under a bound, since a dead design must not hang the run.
    task automatic put(input logic [5:0] v);
        @(posedge core_clk);
        go <= 1'h1;
        val <= v;
        @(posedge core_clk);
        go <= 1'h0;
        for (int i = 0; i < 8 && lk !== 1'h1; i++) begin
            @(posedge core_clk);
            #1;
        end
        if (lk !== 1'h1) begin
            num_errors++;
            results();
        end
    endtask
    // Each row gets a fresh reset, one write and a refused rewrite.
    initial begin
        for (int r = 0; r < 4; r++) begin
            @(posedge core_clk);
            sys_rst <= 1'h1;
            md <= rows[r][3:2];
            t1 <= rows[r][1];
            repeat (2) @(posedge core_clk);
            sys_rst <= 1'h0;
            #1 check("lock", {4'h0, lk}, 5'h00);
            put(rows[r][9:4]);
            check("mult", mult, rows[r][8:4]);
            check("locked", {4'h0, lk}, 5'h01);
            check("en", {3'h0, bad, en}, {4'h0, rows[r][0]});
            put(~rows[r][9:4]);
            repeat (4) @(posedge core_clk);
            #1 check("hold", mult, rows[r][8:4]);
            check("relock", {4'h0, lk}, 5'h01);
        end
        // Strobe on the last reset edge is refused; the next, on the first free edge, lands.
        // The second value breaks the factor floor on purpose to raise the flag.
        @(posedge core_clk);
        sys_rst <= 1'h1;
        md <= 2'h1;
        t1 <= 1'h0;
        @(posedge core_clk);
        go <= 1'h1;
        val <= 6'h2a;
        @(posedge core_clk);
        val <= 6'h23;
        @(posedge core_clk);
        go <= 1'h0;
        sys_rst <= 1'h0;
        repeat (2) @(posedge core_clk);
        #1 check("rstmult", mult, 5'h03);
        check("rstflag", {2'h0, lk, bad, en}, 5'h07);
        // Mode and times-one changes move the clock source without a rewrite.
        @(posedge core_clk);
        md <= 2'h2;
        @(posedge core_clk);
        #1 check("mode2", {3'h0, bad, en}, 5'h00);
        @(posedge core_clk);
        md <= 2'h1;
        t1 <= 1'h1;
        @(posedge core_clk);
        #1 check("timesone", {3'h0, bad, en}, 5'h00);
        @(posedge core_clk);
        t1 <= 1'h0;
        @(posedge core_clk);
        #1 check("back", {3'h0, bad, en}, 5'h03);
        results();
    end
endmodule
`default_nettype wire
